// file: rtl/pin_share_pkg.sv
/*
 Constants, field positions, reset values and enumerations for the shared
 drop-bus / line-clock output pins. Assumes nothing of its surroundings.
*/
package pin_share_pkg;
    // Register addresses (direct, sixteen bit)
    localparam logic [15:0] IO_CTRL_CH7_ADDR  = 16'h8F01;
    localparam logic [15:0] IO_CTRL_CH11_ADDR = 16'hCF01;
    localparam logic [15:0] PAGE_SEL_ADDR     = 16'h00FF;
    localparam logic [15:0] CONFIG_ADDR       = 16'h0110;
    localparam logic [15:0] STATUS_ADDR       = 16'h0111;
    // Indirect access: page value plus offset
    localparam logic [7:0]  IO_CTRL_CH7_PAGE  = 8'h8E;
    localparam logic [7:0]  IO_CTRL_CH11_PAGE = 8'hCE;
    localparam logic [7:0]  IO_CTRL_OFFSET    = 8'h01;
    localparam logic [7:0]  INDIRECT_HI       = 8'h00;
    localparam logic [7:0]  PAGE_STEP         = 8'h01;
    // Field positions
    localparam int INVERT_BIT_CH7    = 2;
    localparam int INVERT_BIT_CH11   = 2;
    localparam int CFG_BUS_EN_BIT    = 0;
    localparam int CFG_STS1_CH7_BIT  = 1;
    localparam int CFG_STS1_CH11_BIT = 2;
    localparam int STAT_FUNC_BIT     = 0;
    localparam int STAT_FULL_BIT     = 1;
    // Reset values
    localparam logic [7:0] IO_CTRL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] PAGE_RESET    = 8'h00;
    // Sizes and timing counts
    localparam int DROP_WIDTH     = 8;
    localparam int FIFO_DEPTH     = 16;
    localparam int LINE_CLK_HALF  = 2;
    localparam int LINE_NIBBLE    = 4;
    // Pin function and line data update edge
    typedef enum logic {FUNC_LINE_CLOCK, FUNC_DROP_DATA} pin_func_e;
    typedef enum logic {EDGE_RISE, EDGE_FALL} update_edge_e;
endpackage : pin_share_pkg

// file: rtl/fifo_if.sv
/*
 Handshake bundle between the pin-share top and its crossing FIFO.
 Assumes the write side is in the register clock domain and the read side
 in the drop bus clock domain.
*/
`timescale 1ns/100ps
interface fifo_if #(
    parameter int WIDTH = 8
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;
    logic             full;
    logic             empty;
    modport buffer (input wr_valid, wr_data, rd_ready,
                    output wr_ready, rd_valid, rd_data, full, empty);
    modport user   (output wr_valid, wr_data, rd_ready,
                    input wr_ready, rd_valid, rd_data, full, empty);
endinterface : fifo_if

// file: rtl/cdc_fifo.sv
/*
 Dual-clock FIFO with gray-coded pointers, flip-flop storage.
 Assumes DEPTH is a power of two and at least four.
*/
`timescale 1ns/100ps
module cdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic wr_clk_i,
    input  wire logic wr_rst_i,
    input  wire logic rd_clk_i,
    input  wire logic rd_rst_i,
    fifo_if.buffer    port_if
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wbin_r;
    logic [AW:0]      wgray_r;
    logic [AW:0]      rbin_r;
    logic [AW:0]      rgray_r;
    logic [AW:0]      wgray_s1_r;
    logic [AW:0]      wgray_s2_r;
    logic [AW:0]      rgray_s1_r;
    logic [AW:0]      rgray_s2_r;

    // Pointer arithmetic and honest flags
    wire          wr_fire  = port_if.wr_valid & port_if.wr_ready;
    wire          rd_fire  = port_if.rd_valid & port_if.rd_ready;
    wire [AW:0]   wbin_nxt = wbin_r + (AW+1)'(wr_fire);
    wire [AW:0]   rbin_nxt = rbin_r + (AW+1)'(rd_fire);
    assign port_if.full     = wgray_r == {~rgray_s2_r[AW:AW-1], rgray_s2_r[AW-2:0]};
    assign port_if.empty    = rgray_r == wgray_s2_r;
    assign port_if.wr_ready = ~port_if.full;
    assign port_if.rd_valid = ~port_if.empty;
    assign port_if.rd_data  = mem_r[rbin_r[AW-1:0]];

    // Storage needs no reset; a word is read only after its pointer crossed
    always_ff @(posedge wr_clk_i) begin
        if (wr_fire) begin
            mem_r[wbin_r[AW-1:0]] <= port_if.wr_data;
        end
    end

    // Write pointer and read pointer sync into write domain
    always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
        if (wr_rst_i) begin
            wbin_r     <= '0;
            wgray_r    <= '0;
            rgray_s1_r <= '0;
            rgray_s2_r <= '0;
        end else begin
            wbin_r     <= wbin_nxt;
            wgray_r    <= (wbin_nxt >> 1) ^ wbin_nxt;
            rgray_s1_r <= rgray_r;
            rgray_s2_r <= rgray_s1_r;
        end
    end

    // Read pointer and write pointer sync into read domain
    always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
        if (rd_rst_i) begin
            rbin_r     <= '0;
            rgray_r    <= '0;
            wgray_s1_r <= '0;
            wgray_s2_r <= '0;
        end else begin
            rbin_r     <= rbin_nxt;
            rgray_r    <= (rbin_nxt >> 1) ^ rbin_nxt;
            wgray_s1_r <= wgray_r;
            wgray_s2_r <= wgray_s1_r;
        end
    end
endmodule : cdc_fifo

// file: rtl/drop_bus_line_clock_pin_share.sv
/*
 Shared output pins: channel 3 drop bus data bits 6 and 7, or the line
 transmit clocks of channels 7 and 11, plus the line data serialisers and
 the channel I/O control registers on the byte-wide processor port.
 Assumes the drop bus clock runs free in both pin functions, and that the
 stream and processor inputs come from logic on sys_clk_i.
*/
`timescale 1ns/100ps
module drop_bus_line_clock_pin_share #(
    parameter int LINE_CLK_HALF = pin_share_pkg::LINE_CLK_HALF,
    parameter int FIFO_DEPTH    = pin_share_pkg::FIFO_DEPTH
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       drop_bus_clock_ch3_i,
    input  wire logic [15:0] mp_addr_i,
    input  wire logic [7:0] mp_wdata_i,
    input  wire logic       mp_wr_i,
    input  wire logic       mp_rd_i,
    output logic      [7:0] mp_rdata_o,
    input  wire logic [7:0] stream_data_i,
    input  wire logic       stream_valid_i,
    output logic            stream_ready_o,
    output logic      [5:0] drop_bus_data_ch3_o,
    output logic            drop_data6_line_clock_ch7_o,
    output logic            drop_data7_line_clock_ch11_o,
    output logic            line_data_out_ch7_o,
    output logic            line_data_out_ch11_o
);
    localparam int CW  = $clog2(LINE_CLK_HALF + 1);
    localparam int NBW = $clog2(pin_share_pkg::LINE_NIBBLE + 1);
    localparam int DW  = pin_share_pkg::DROP_WIDTH;

    // Indirect window: page value plus one forms the high address byte
    function automatic logic [15:0] eff_addr(input logic [15:0] a, input logic [7:0] pg);
        if (a[15:8] == pin_share_pkg::INDIRECT_HI && a != pin_share_pkg::PAGE_SEL_ADDR) begin
            eff_addr = {pg + pin_share_pkg::PAGE_STEP, a[7:0]};
        end else begin
            eff_addr = a;
        end
    endfunction : eff_addr

    logic [7:0]  page_r;
    logic [7:0]  io_ch7_r;
    logic [7:0]  io_ch11_r;
    logic [7:0]  config_r;
    logic [7:0]  rdata_r;
    logic        func_s1_r;
    logic        func_s2_r;
    pin_share_pkg::pin_func_e func_r;   // Active pin function, link domain

    fifo_if #(.WIDTH(DW)) fifo_bus ();

    // Register decode, both windows resolve to one effective address
    wire [15:0] ea      = eff_addr(mp_addr_i, page_r);
    wire        wr_page = mp_wr_i && mp_addr_i == pin_share_pkg::PAGE_SEL_ADDR;
    wire        wr_io7  = mp_wr_i && ea == pin_share_pkg::IO_CTRL_CH7_ADDR;
    wire        wr_io11 = mp_wr_i && ea == pin_share_pkg::IO_CTRL_CH11_ADDR;
    wire        wr_cfg  = mp_wr_i && ea == pin_share_pkg::CONFIG_ADDR;
    wire [7:0]  status  = {6'h00, fifo_bus.full, func_s2_r};

    // Read selection, unmapped addresses read zero
    logic [7:0] rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (mp_rd_i) begin
            case (ea)
                pin_share_pkg::PAGE_SEL_ADDR:     rdata_nxt = page_r;
                pin_share_pkg::IO_CTRL_CH7_ADDR:  rdata_nxt = io_ch7_r;
                pin_share_pkg::IO_CTRL_CH11_ADDR: rdata_nxt = io_ch11_r;
                pin_share_pkg::CONFIG_ADDR:       rdata_nxt = config_r;
                pin_share_pkg::STATUS_ADDR:       rdata_nxt = status;
                default:                          rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register file on the processor clock
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_r    <= pin_share_pkg::PAGE_RESET;
            io_ch7_r  <= pin_share_pkg::IO_CTRL_RESET;
            io_ch11_r <= pin_share_pkg::IO_CTRL_RESET;
            config_r  <= pin_share_pkg::CONFIG_RESET;
            rdata_r   <= 8'h00;
        end else begin
            if (wr_page) page_r <= mp_wdata_i;
            if (wr_io7) io_ch7_r <= mp_wdata_i;
            if (wr_io11) io_ch11_r <= mp_wdata_i;
            if (wr_cfg) config_r <= mp_wdata_i;
            rdata_r <= rdata_nxt;
        end
    end

    // Active pin function back into the processor domain
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            func_s1_r <= 1'b0;
            func_s2_r <= 1'b0;
        end else begin
            func_s1_r <= func_r == pin_share_pkg::FUNC_DROP_DATA;
            func_s2_r <= func_s1_r;
        end
    end

    assign mp_rdata_o     = rdata_r;
    assign stream_ready_o = fifo_bus.wr_ready;
    assign fifo_bus.wr_valid = stream_valid_i;
    assign fifo_bus.wr_data  = stream_data_i;

    // Link domain reset: asserts at once, releases on the drop bus clock
    logic link_rst_s1_r;
    logic link_rst_r;
    always_ff @(posedge drop_bus_clock_ch3_i or posedge rst_i) begin
        if (rst_i) begin
            link_rst_s1_r <= 1'b1;
            link_rst_r    <= 1'b1;
        end else begin
            link_rst_s1_r <= 1'b0;
            link_rst_r    <= link_rst_s1_r;
        end
    end

    cdc_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk_i (sys_clk_i),
        .wr_rst_i (rst_i),
        .rd_clk_i (drop_bus_clock_ch3_i),
        .rd_rst_i (link_rst_r),
        .port_if  (fifo_bus.buffer)
    );

    // Configuration levels cross bit by bit; each bit stands alone
    logic [4:0] cfg_s1_r;
    logic [4:0] cfg_s2_r;
    wire  [4:0] cfg_src = {io_ch11_r[pin_share_pkg::INVERT_BIT_CH11],
                           io_ch7_r[pin_share_pkg::INVERT_BIT_CH7],
                           config_r[pin_share_pkg::CFG_STS1_CH11_BIT],
                           config_r[pin_share_pkg::CFG_STS1_CH7_BIT],
                           config_r[pin_share_pkg::CFG_BUS_EN_BIT]};
    always_ff @(posedge drop_bus_clock_ch3_i or posedge link_rst_r) begin
        if (link_rst_r) begin
            cfg_s1_r <= 5'h00;
            cfg_s2_r <= 5'h00;
        end else begin
            cfg_s1_r <= cfg_src;
            cfg_s2_r <= cfg_s1_r;
        end
    end
    wire       bus_en_s = cfg_s2_r[0];
    wire [1:0] sts1_s   = cfg_s2_r[2:1];
    wire [1:0] invert_s = cfg_s2_r[4:3];

    // Line clock divider, free running on the drop bus clock
    logic [CW-1:0] half_cnt_r;
    logic          line_clk_r;
    wire           half_done    = half_cnt_r == CW'(LINE_CLK_HALF - 1);
    wire [CW-1:0]  half_cnt_nxt = half_done ? '0 : half_cnt_r + CW'(1);
    wire           line_clk_nxt = half_done ? ~line_clk_r : line_clk_r;
    wire           rise_ev      = half_done & ~line_clk_r;
    wire           fall_ev      = half_done & line_clk_r;

    // Function switch only while the clock is low and stays low: no runt pulse
    pin_share_pkg::pin_func_e func_nxt;
    wire sel_en = ~line_clk_r & ~half_done;
    assign func_nxt = !sel_en ? func_r :
                      bus_en_s ? pin_share_pkg::FUNC_DROP_DATA
                               : pin_share_pkg::FUNC_LINE_CLOCK;
    wire drop_mode = func_r == pin_share_pkg::FUNC_DROP_DATA;

    // FIFO drain: every drop clock in bus mode, one byte per two nibbles in line mode
    logic [1:0] chan_idle;
    wire  line_load = ~drop_mode & fifo_bus.rd_valid & (&chan_idle);
    wire  drop_pop  = drop_mode & fifo_bus.rd_valid;
    assign fifo_bus.rd_ready = drop_mode | (&chan_idle);

    logic [DW-1:0] drop_data_r;
    logic          pin6_r;
    logic          pin7_r;
    wire  [DW-1:0] drop_data_nxt = drop_pop ? fifo_bus.rd_data : drop_data_r;
    wire  drop_nxt = func_nxt == pin_share_pkg::FUNC_DROP_DATA;
    wire  pin6_nxt = drop_nxt ? drop_data_nxt[6] : line_clk_nxt;
    wire  pin7_nxt = drop_nxt ? drop_data_nxt[7] : line_clk_nxt;

    // Pin registers in the drop clock domain; all change on its rising edge
    always_ff @(posedge drop_bus_clock_ch3_i or posedge link_rst_r) begin
        if (link_rst_r) begin
            half_cnt_r  <= '0;
            line_clk_r  <= 1'b0;
            func_r      <= pin_share_pkg::FUNC_LINE_CLOCK;
            drop_data_r <= '0;
            pin6_r      <= 1'b0;
            pin7_r      <= 1'b0;
        end else begin
            half_cnt_r  <= half_cnt_nxt;
            line_clk_r  <= line_clk_nxt;
            func_r      <= func_nxt;
            drop_data_r <= drop_data_nxt;
            pin6_r      <= pin6_nxt;
            pin7_r      <= pin7_nxt;
        end
    end

    // Per channel serialiser: index 0 is channel 7 (low nibble), 1 is channel 11
    logic [1:0] line_data_w;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : ch_g
            pin_share_pkg::update_edge_e edge_sel;
            logic [pin_share_pkg::LINE_NIBBLE-1:0] shift_r;
            logic [NBW-1:0]                        bits_r;
            logic                                  data_r;
            assign edge_sel = (invert_s[g] & ~sts1_s[g]) ? pin_share_pkg::EDGE_FALL
                                                         : pin_share_pkg::EDGE_RISE;
            wire upd = (edge_sel == pin_share_pkg::EDGE_FALL) ? fall_ev : rise_ev;
            wire step = ~drop_mode & upd & (bits_r != '0);
            assign chan_idle[g]   = bits_r == '0;
            assign line_data_w[g] = data_r;

            // Shift out one bit per chosen line clock edge
            always_ff @(posedge drop_bus_clock_ch3_i or posedge link_rst_r) begin
                if (link_rst_r) begin
                    shift_r <= '0;
                    bits_r  <= '0;
                    data_r  <= 1'b0;
                end else if (line_load) begin
                    shift_r <= fifo_bus.rd_data[g*pin_share_pkg::LINE_NIBBLE +:
                                                pin_share_pkg::LINE_NIBBLE];
                    bits_r  <= NBW'(pin_share_pkg::LINE_NIBBLE);
                end else if (step) begin
                    data_r  <= shift_r[0];
                    shift_r <= shift_r >> 1;
                    bits_r  <= bits_r - NBW'(1);
                end
            end
        end
    endgenerate

    assign drop_bus_data_ch3_o          = drop_data_r[5:0];
    assign drop_data6_line_clock_ch7_o  = pin6_r;
    assign drop_data7_line_clock_ch11_o = pin7_r;
    assign line_data_out_ch7_o          = line_data_w[0];
    assign line_data_out_ch11_o         = line_data_w[1];

    // Checks on the processor port
    a_direct_write_ch7: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mp_wr_i && mp_addr_i == pin_share_pkg::IO_CTRL_CH7_ADDR
        |=> io_ch7_r == $past(mp_wdata_i))
        else $error("direct write to channel 7 control lost");
    a_indirect_write_ch11: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mp_wr_i && mp_addr_i == {pin_share_pkg::INDIRECT_HI, pin_share_pkg::IO_CTRL_OFFSET}
        && page_r == pin_share_pkg::IO_CTRL_CH11_PAGE
        |=> io_ch11_r == $past(mp_wdata_i))
        else $error("indirect write to channel 11 control lost");

    // Checks on the pin side
    a_pin_data_sel: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        drop_mode |-> pin6_r == drop_data_r[6] && pin7_r == drop_data_r[7])
        else $error("shared pins do not carry drop bits 6 and 7");
    a_pin_clock_sel: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        !drop_mode |-> pin6_r == line_clk_r && pin7_r == line_clk_r)
        else $error("shared pins do not carry the line clock");
    a_sel_follows_en: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        bus_en_s && !drop_mode |-> ##[1:8] drop_mode || !bus_en_s)
        else $error("pin function did not follow bus enable");
    a_drop_rise_only: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        $changed(drop_data_r) |-> $past(drop_pop))
        else $error("drop data changed without a pop");
    a_drop_byte_order: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        drop_pop |=> drop_data_r == $past(fifo_bus.rd_data))
        else $error("drop byte not presented in bit order");
    a_rise_update: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        $changed(line_data_w[0]) && $past(ch_g[0].edge_sel == pin_share_pkg::EDGE_RISE)
        |-> $rose(line_clk_r))
        else $error("channel 7 data moved off the rising edge");
    a_fall_update: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        $changed(line_data_w[1]) && $past(invert_s[1] && !sts1_s[1])
        |-> $fell(line_clk_r))
        else $error("inverted channel 11 data moved off the falling edge");
    a_sts1_rising: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        $changed(line_data_w[0]) && $past(sts1_s[0]) |-> $rose(line_clk_r))
        else $error("STS-1 channel 7 data updated on falling edge");
    a_switch_clock_low: assert property (@(posedge drop_bus_clock_ch3_i) disable iff (link_rst_r)
        $changed(func_r) |-> !$past(line_clk_r) && !line_clk_r)
        else $error("pin function switched while line clock high");
endmodule : drop_bus_line_clock_pin_share

// file: test/liu_model.sv
/*
 Far-side line receiver watching the shared pins, line data and drop bus.
 Assumes a free-running link clock and outputs that move only at its rising edge.
*/
`timescale 1ns/100ps
module liu_model (
    input  wire logic       link_clk_i,
    input  wire logic       clear_i,
    input  wire logic       drop_mode_i,
    input  wire logic       fall7_i,
    input  wire logic       fall11_i,
    input  wire logic       pin7_i,
    input  wire logic       pin11_i,
    input  wire logic       data7_i,
    input  wire logic       data11_i,
    input  wire logic [5:0] drop_i,
    output int              bad_o,
    output int              moves_o,
    output int              period_o
);
    logic       p7, p11, d7, d11;
    logic [9:0] snap;
    int         cnt;
    logic       glitch = 1'b0;
    // Sample just after each rising link edge, so the pin edge and data move are seen together
    always @(posedge link_clk_i) begin
        #1;
        cnt = cnt + 1;
        if ({p7, pin7_i} === 2'h1) begin
            period_o = cnt;
            cnt = 0;
        end
        if (clear_i) begin
            bad_o = 0;
            moves_o = 0;
        end else if (glitch) begin
            bad_o++;
        end
        if (!clear_i && !drop_mode_i) begin
            if (d7 !== data7_i) begin
                moves_o++;
                if ({p7, pin7_i} !== (fall7_i ? 2'h2 : 2'h1)) bad_o++;
            end
            if (d11 !== data11_i) begin
                moves_o++;
                if ({p11, pin11_i} !== (fall11_i ? 2'h2 : 2'h1)) bad_o++;
            end
        end
        {p7, p11, d7, d11} = {pin7_i, pin11_i, data7_i, data11_i};
        snap = {pin11_i, pin7_i, drop_i, data7_i, data11_i};
    end
    // Nothing may move between rising link edges; a glitch shows up here
    always @(negedge link_clk_i) begin
        glitch = !clear_i && snap !== {pin11_i, pin7_i, drop_i, data7_i, data11_i};
    end
endmodule : liu_model

// file: test/tb_top.sv
/*
 Self-checking bench for the shared drop-bus / line-clock pins.
 Assumes the design package and FIFO files are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] A7 = pin_share_pkg::IO_CTRL_CH7_ADDR;
    localparam logic [15:0] A11 = pin_share_pkg::IO_CTRL_CH11_ADDR;
    localparam logic [15:0] ACFG = pin_share_pkg::CONFIG_ADDR;
    localparam logic [15:0] ASTAT = pin_share_pkg::STATUS_ADDR;
    localparam logic [15:0] APAGE = pin_share_pkg::PAGE_SEL_ADDR;
    localparam logic [15:0] AWIN = {pin_share_pkg::INDIRECT_HI, pin_share_pkg::IO_CTRL_OFFSET};
    logic        sys_clk = 0, rst = 1, lclk = 0, wr_s = 0, rd_s = 0, s_valid = 0, s_ready;
    logic        clr = 1, dmode = 0, f7 = 0, f11 = 0, pin7, pin11, ld7, ld11, mon = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, s_data = 8'h00, rdata, last;
    logic [5:0]  drop;
    logic [7:0]  seen[$];
    int          bad, moves, period, err_count = 0, cmp_count = 0;
    // Clocks: the link clock is free-running and out of phase with the system clock
    always #12.5 sys_clk = ~sys_clk;
    initial #1.7 forever #3 lclk = ~lclk;
    drop_bus_line_clock_pin_share #(.LINE_CLK_HALF(2), .FIFO_DEPTH(16)) uut (
        .sys_clk_i(sys_clk), .rst_i(rst), .drop_bus_clock_ch3_i(lclk), .mp_addr_i(addr),
        .mp_wdata_i(wdata), .mp_wr_i(wr_s), .mp_rd_i(rd_s), .mp_rdata_o(rdata),
        .stream_data_i(s_data), .stream_valid_i(s_valid), .stream_ready_o(s_ready),
        .drop_bus_data_ch3_o(drop), .drop_data6_line_clock_ch7_o(pin7),
        .drop_data7_line_clock_ch11_o(pin11), .line_data_out_ch7_o(ld7),
        .line_data_out_ch11_o(ld11));
    liu_model far_end (
        .link_clk_i(lclk), .clear_i(clr), .drop_mode_i(dmode), .fall7_i(f7), .fall11_i(f11),
        .pin7_i(pin7), .pin11_i(pin11), .data7_i(ld7), .data11_i(ld11), .drop_i(drop),
        .bad_o(bad), .moves_o(moves), .period_o(period));
    // Drop bus monitor: records each new byte, bit 7 on the second shared pin
    always @(posedge lclk) begin
        #1;
        if (!mon) last = {pin11, pin7, drop};
        else if ({pin11, pin7, drop} !== last) begin
            last = {pin11, pin7, drop};
            seen.push_back(last);
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk); #1;
        addr = a; wdata = d; wr_s = 1;
        @(posedge sys_clk); #1;
        wr_s = 0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk); #1;
        addr = a; rd_s = 1;
        @(posedge sys_clk); #1;
        rd_s = 0;
        chk(rdata, exp, "register read");
    endtask : rd
    // Reset values, direct and paged access, unmapped place
    task automatic t_regs;
        rd(A7, 8'h00);
        rd(A11, 8'h00);
        wr(APAGE, pin_share_pkg::IO_CTRL_CH7_PAGE);
        wr(AWIN, 8'h5A);
        rd(A7, 8'h5A);
        wr(A11, 8'hA5);
        wr(APAGE, pin_share_pkg::IO_CTRL_CH11_PAGE);
        rd(AWIN, 8'hA5);
        wr(16'h1234, 8'hFF);
        rd(16'h1234, 8'h00);
    endtask : t_regs
    // One byte out in line mode: 0x3C leaves channel 7 high and channel 11 low
    task automatic t_line(input logic [7:0] ctl, input logic [7:0] cfg, input logic fe);
        wr(A7, ctl);
        wr(A11, ctl);
        wr(ACFG, cfg);
        repeat (40) @(posedge sys_clk); #1;
        f7 = fe; f11 = fe; clr = 1;
        repeat (2) @(posedge sys_clk); #1;
        clr = 0; s_data = 8'h3C; s_valid = 1;
        @(posedge sys_clk); #1;
        s_valid = 0;
        repeat (40) @(posedge sys_clk); #1;
        chk({7'h0, bad == 0}, 8'h01, "line data edge");
        chk({7'h0, moves >= 3}, 8'h01, "line data moved");
        chk({6'h0, ld11, ld7}, 8'h01, "line nibble split");
        chk(8'(period), 8'h04, "line clock period");
        rd(ASTAT, 8'h00);
    endtask : t_line
    // Fill until refused while the slow line side drains, then let it empty
    task automatic t_fill;
        int n;
        s_valid = 1;
        for (n = 0; n < 40 && s_ready; n++) begin
            s_data = 8'(n + 1);
            @(posedge sys_clk); #1;
        end
        s_valid = 0;
        chk({7'h0, n >= 16 && n < 40}, 8'h01, "fifo fill count");
        repeat (150) @(posedge sys_clk); #1;
        chk({7'h0, s_ready}, 8'h01, "fifo drained");
        chk({7'h0, bad == 0}, 8'h01, "line edge under load");
    endtask : t_fill
    // Bus enabled: bytes appear whole on the drop pins, MSB on the channel 11 pin
    task automatic t_drop;
        logic [7:0] pat[6] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hF0, 8'h0F};
        dmode = 1;
        wr(ACFG, 8'h01);
        repeat (20) @(posedge sys_clk); #1;
        rd(ASTAT, 8'h01);
        mon = 1;
        for (int i = 0; i < 6; i++) begin
            s_data = pat[i]; s_valid = 1;
            @(posedge sys_clk); #1;
        end
        s_valid = 0;
        repeat (20) @(posedge sys_clk); #1;
        mon = 0;
        chk(8'(seen.size()), 8'h06, "drop byte count");
        for (int i = 0; i < 6 && i < seen.size(); i++) chk(seen[i], pat[i], "drop byte");
        chk({7'h0, bad == 0}, 8'h01, "drop timing");
    endtask : t_drop
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // Main sequence; reset held for five system clocks
    initial begin
        repeat (5) @(posedge sys_clk); #1;
        rst = 0;
        t_regs();
        t_line(8'h00, 8'h00, 1'b0);
        t_line(8'h04, 8'h00, 1'b1);
        t_line(8'h04, 8'h06, 1'b0);
        t_fill();
        t_drop();
        results();
    end
    // Watchdog well beyond the expected run of about 13 us
    initial begin
        #200000;
        err_count++;
        results();
    end
endmodule : tb_top
